/* logic/cpmc_pkg.sv */
// Shared constants and state types of the CPU power mode control block
package cpmc_pkg;

   // Register byte offsets on the Avalon-MM slave
   localparam logic [3:0] OFS_POWER_CONTROL = 4'h0;
   localparam logic [3:0] OFS_CONFIG = 4'h4;
   localparam logic [3:0] OFS_STATUS = 4'h8;
   localparam logic [3:0] OFS_WD_KICK = 4'hc;

   // Power control register fields
   localparam int PC_IDLE_BIT = 0;
   localparam int PC_STOP_BIT = 1;
   localparam int PC_GPF_LSB = 2;
   localparam int PC_GPF_W = 6;

   // Config register fields
   localparam int CFG_WD_EN_BIT = 0;
   localparam int CFG_WD_LOCK_BIT = 1;
   localparam int CFG_MCM_EN_BIT = 2;
   localparam int CFG_HAZARD_EN_BIT = 3;

   // Status register fields
   localparam int ST_MODE_LSB = 0;
   localparam int ST_WAKE_LOCK_BIT = 2;
   localparam int ST_CAUSE_LSB = 3;

   // Reset values
   localparam logic CFG_WD_EN_RST = 1'b1;
   localparam logic CFG_WD_LOCK_RST = 1'b0;
   localparam logic CFG_MCM_EN_RST = 1'b0;
   localparam logic CFG_HAZARD_EN_RST = 1'b1;
   localparam logic [15:0] RESET_VECTOR = 16'h0000;

   // Reset causes
   localparam logic [1:0] CAUSE_NONE = 2'h0;
   localparam logic [1:0] CAUSE_PIN = 2'h1;
   localparam logic [1:0] CAUSE_WATCHDOG = 2'h2;
   localparam logic [1:0] CAUSE_MISSING_CLK = 2'h3;

   // Timing
   localparam int CLK_MHZ = 50;
   localparam int MCM_TIMEOUT_US = 100;
   localparam int MCM_CYCLES = MCM_TIMEOUT_US * CLK_MHZ;
   localparam int WD_CYCLES = 65536;

   // Power modes, Gray coded along run, pending, idle, stop
   typedef enum logic [1:0] {
      MODE_RUN = 2'h0,
      MODE_PEND = 2'h1,
      MODE_IDLE = 2'h3,
      MODE_STOP = 2'h2
   } cpmc_mode_t;

   typedef struct packed {
      cpmc_mode_t mode;
      logic pend_stop;
      logic [PC_GPF_W-1:0] gp_flags;
      logic wd_en;
      logic wd_lock;
      logic mcm_en;
      logic hazard_en;
      logic wake_lock;
      logic irq_in_exec;
      logic [1:0] cause;
      logic ack;
      logic [31:0] rdata;
      logic reset_req;
      logic wake_pulse;
      logic [15:0] restart_pc;
      logic pin_s1;
      logic pin_s2;
      logic pin_s3;
   } cpmc_regs_t;

   localparam cpmc_regs_t REGS_RST = '{
      mode: MODE_RUN, pend_stop: 1'b0, gp_flags: '0,
      wd_en: CFG_WD_EN_RST, wd_lock: CFG_WD_LOCK_RST,
      mcm_en: CFG_MCM_EN_RST, hazard_en: CFG_HAZARD_EN_RST,
      wake_lock: 1'b0, irq_in_exec: 1'b0, cause: CAUSE_NONE,
      ack: 1'b0, rdata: 32'h0000_0000, reset_req: 1'b0,
      wake_pulse: 1'b0, restart_pc: RESET_VECTOR,
      pin_s1: 1'b1, pin_s2: 1'b1, pin_s3: 1'b1
   };

endpackage

/* logic/cpmc_countdown.sv */
// Down counter that pulses once when a running count expires
`timescale 1ns/1ps
module cpmc_countdown
   import cpmc_pkg::*;
#(
   parameter int WIDTH = 17,
   parameter logic [WIDTH-1:0] LOAD = 17'h10000
)(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ce,
   // Control
   input wire logic run,
   input wire logic restart,
   // Event
   output logic expired
);

   typedef struct packed {
      logic [WIDTH-1:0] count;
      logic expired;
   } cpmc_cnt_t;

   cpmc_cnt_t r_reg;
   cpmc_cnt_t r_next;

   always_comb
   begin
      r_next = r_reg;
      r_next.expired = 1'b0;
      if (restart || !run)
      begin
         r_next.count = LOAD;
      end
      else if (r_reg.count <= {{(WIDTH-1){1'b0}}, 1'b1})
      begin
         r_next.expired = 1'b1;
         r_next.count = LOAD;
      end
      else
      begin
         r_next.count = r_reg.count - {{(WIDTH-1){1'b0}}, 1'b1};
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         r_reg <= '{count: LOAD, expired: 1'b0};
      end
      else if (ce)
      begin
         r_reg <= r_next;
      end
   end

   assign expired = r_reg.expired;

endmodule

/* logic/cpmc_power_ctrl.sv */
// CPU power mode control: idle and stop modes with an Avalon-MM register slave
//
// Decided for this implementation: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps

// Contract
// - Two low-power modes exist, idle and stop, each chosen by a software-written bit.
// - Idle stops instruction execution while clocks and peripherals keep running.
// - Stop halts the core, disables interrupts and timers but the monitor, stops the oscillator.
// - Idle is entered only after the instruction that set the idle bit has completed.
// - While idle, register and memory contents stay unchanged.
// - Idle ends only on an enabled interrupt or an internal or external reset.
// - An interrupt ending idle clears the idle bit, resumes the core and gets serviced.
// - After that interrupt returns, execution resumes after the idle-setting instruction.
// - A reset ending idle runs the normal reset sequence and restarts at address 0x0000.
// - An enabled watchdog keeps counting in idle and ends it with an internal reset.
// - A single-byte follower plus an interrupt during the write can block later wakes.
// - Once the oscillator is off, only a reset resumes operation.
// - Stop sits at bit 1 and idle at bit 0 of the power control register, both read zero.
// - Writing the stop bit enters stop after the instruction; only a reset ends it, at zero.
// - An enabled missing clock monitor resets the device after its 100 us timeout in stop.
module cpmc_power_ctrl
   import cpmc_pkg::*;
#(
   parameter int MCM_TIMEOUT_CYCLES = MCM_CYCLES,
   parameter int WATCHDOG_CYCLES = WD_CYCLES
)(
   // Clock, reset, enable
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ce,
   // Avalon-MM slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Core sequencer
   input wire logic instr_done,
   input wire logic next_single_byte,
   output logic cpu_clk_en,
   output logic [15:0] restart_pc,
   output logic [1:0] power_mode,
   // Interrupt controller
   input wire logic irq_pending,
   output logic int_enable,
   output logic irq_wake,
   // Reset logic and pin
   input wire logic ext_reset_pin_n,
   output logic reset_req,
   // Clock sources and peripherals
   output logic periph_clk_en,
   output logic timer_en,
   output logic int_osc_en
);

   cpmc_regs_t r_reg;
   cpmc_regs_t r_next;

   logic acc_done;
   logic wr_power_control_reg;
   logic wr_cfg;
   logic wr_kick;
   logic wd_expired;
   logic mcm_expired;
   logic pin_reset;
   logic reset_any;
   logic [1:0] reset_cause;
   logic wd_run;
   logic mcm_run;
   logic [31:0] rd_mux;

   // Bus access completes on the second cycle, one wait state
   assign acc_done = (avs_read || avs_write) && r_reg.ack;
   assign wr_power_control_reg = acc_done && avs_write && avs_address == OFS_POWER_CONTROL
      && avs_byteenable[0];
   assign wr_cfg = acc_done && avs_write && avs_address == OFS_CONFIG && avs_byteenable[0];
   assign wr_kick = acc_done && avs_write && avs_address == OFS_WD_KICK;

   // Pin reset seen on a synchronised falling edge
   assign pin_reset = r_reg.pin_s3 && !r_reg.pin_s2;

   // Watchdog stops with the timers in stop
   assign wd_run = r_reg.wd_en && r_reg.mode != MODE_STOP;
   // Monitor only watches while the oscillator is off
   assign mcm_run = r_reg.mcm_en && r_reg.mode == MODE_STOP;

   cpmc_countdown #(
      .WIDTH(32),
      .LOAD(32'(WATCHDOG_CYCLES))
   ) u_watchdog_counter (
      .clk(clk),
      .sys_rst(sys_rst),
      .ce(ce),
      .run(wd_run),
      .restart(wr_kick || reset_any),
      .expired(wd_expired)
   );

   cpmc_countdown #(
      .WIDTH(32),
      .LOAD(32'(MCM_TIMEOUT_CYCLES))
   ) u_missing_clock_monitor (
      .clk(clk),
      .sys_rst(sys_rst),
      .ce(ce),
      .run(mcm_run),
      .restart(reset_any),
      .expired(mcm_expired)
   );

   always_comb
   begin
      reset_any = 1'b1;
      reset_cause = CAUSE_NONE;
      if (pin_reset)
      begin
         reset_cause = CAUSE_PIN;
      end
      else if (wd_expired)
      begin
         reset_cause = CAUSE_WATCHDOG;
      end
      else if (mcm_expired)
      begin
         reset_cause = CAUSE_MISSING_CLK;
      end
      else
      begin
         reset_any = 1'b0;
      end
   end

   always_comb
   begin
      rd_mux = 32'h0000_0000;
      case (avs_address)
         OFS_POWER_CONTROL:
         begin
            // Mode select bits always read as zero
            rd_mux[PC_GPF_LSB +: PC_GPF_W] = r_reg.gp_flags;
         end
         OFS_CONFIG:
         begin
            rd_mux[CFG_WD_EN_BIT] = r_reg.wd_en;
            rd_mux[CFG_WD_LOCK_BIT] = r_reg.wd_lock;
            rd_mux[CFG_MCM_EN_BIT] = r_reg.mcm_en;
            rd_mux[CFG_HAZARD_EN_BIT] = r_reg.hazard_en;
         end
         OFS_STATUS:
         begin
            rd_mux[ST_MODE_LSB +: 2] = r_reg.mode;
            rd_mux[ST_WAKE_LOCK_BIT] = r_reg.wake_lock;
            rd_mux[ST_CAUSE_LSB +: 2] = r_reg.cause;
         end
         default:
         begin
            rd_mux = 32'h0000_0000;
         end
      endcase
   end

   always_comb
   begin
      r_next = r_reg;
      r_next.pin_s1 = ext_reset_pin_n;
      r_next.pin_s2 = r_reg.pin_s1;
      r_next.pin_s3 = r_reg.pin_s2;
      r_next.reset_req = 1'b0;
      r_next.wake_pulse = 1'b0;
      r_next.ack = (avs_read || avs_write) && !r_reg.ack;
      if (avs_read && !r_reg.ack)
      begin
         r_next.rdata = rd_mux;
      end
      // Interrupt seen while the idle-setting write is still executing
      if (r_reg.mode == MODE_PEND && irq_pending)
      begin
         r_next.irq_in_exec = 1'b1;
      end
      if (wr_power_control_reg)
      begin
         r_next.gp_flags = avs_writedata[PC_GPF_LSB +: PC_GPF_W];
      end
      if (wr_cfg)
      begin
         r_next.mcm_en = avs_writedata[CFG_MCM_EN_BIT];
         r_next.hazard_en = avs_writedata[CFG_HAZARD_EN_BIT];
         // Lock is sticky until reset and pins the watchdog on, even in its own write
         r_next.wd_lock = r_reg.wd_lock || avs_writedata[CFG_WD_LOCK_BIT];
         if (!r_reg.wd_lock && !avs_writedata[CFG_WD_LOCK_BIT])
         begin
            r_next.wd_en = avs_writedata[CFG_WD_EN_BIT];
         end
         else
         begin
            r_next.wd_en = 1'b1;
         end
      end
      case (r_reg.mode)
         MODE_RUN:
         begin
            // Stop wins when software sets both select bits
            if (wr_power_control_reg && (avs_writedata[PC_STOP_BIT] || avs_writedata[PC_IDLE_BIT]))
            begin
               r_next.mode = MODE_PEND;
               r_next.pend_stop = avs_writedata[PC_STOP_BIT];
               r_next.irq_in_exec = 1'b0;
            end
         end
         MODE_PEND:
         begin
            // Wait for the writing instruction to retire
            if (instr_done && r_reg.pend_stop)
            begin
               r_next.mode = MODE_STOP;
            end
            else if (instr_done)
            begin
               r_next.mode = MODE_IDLE;
               if (r_reg.hazard_en && next_single_byte && (r_reg.irq_in_exec || irq_pending))
               begin
                  r_next.wake_lock = 1'b1;
               end
            end
         end
         MODE_IDLE:
         begin
            // Interrupts are ignored once the wake path is wedged
            if (irq_pending && !r_reg.wake_lock)
            begin
               r_next.mode = MODE_RUN;
               r_next.wake_pulse = 1'b1;
            end
         end
         MODE_STOP:
         begin
            r_next.mode = MODE_STOP;
         end
         default:
         begin
            r_next.mode = MODE_RUN;
         end
      endcase
      // Internal or pin reset: normal reset sequence from the reset vector
      if (reset_any)
      begin
         r_next = REGS_RST;
         r_next.cause = reset_cause;
         r_next.reset_req = 1'b1;
         r_next.restart_pc = RESET_VECTOR;
         r_next.pin_s1 = ext_reset_pin_n;
         r_next.pin_s2 = r_reg.pin_s1;
         r_next.pin_s3 = r_reg.pin_s2;
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         r_reg <= REGS_RST;
      end
      else if (ce)
      begin
         r_reg <= r_next;
      end
   end

   // Core clock gated off in idle and stop so its state holds
   assign cpu_clk_en = r_reg.mode == MODE_RUN || r_reg.mode == MODE_PEND;
   assign periph_clk_en = r_reg.mode != MODE_STOP;
   assign timer_en = r_reg.mode != MODE_STOP;
   assign int_enable = r_reg.mode != MODE_STOP;
   assign int_osc_en = r_reg.mode != MODE_STOP;
   // PC is untouched on a wake, so the core resumes after the writing instruction
   assign irq_wake = r_reg.wake_pulse;
   assign reset_req = r_reg.reset_req;
   assign restart_pc = r_reg.restart_pc;
   assign power_mode = r_reg.mode;
   assign avs_readdata = r_reg.rdata;
   assign avs_waitrequest = (avs_read || avs_write) && !r_reg.ack;

   sequence s_mode_write;
      ce && r_reg.mode == MODE_RUN && wr_power_control_reg && !reset_any
         && (avs_writedata[PC_IDLE_BIT] || avs_writedata[PC_STOP_BIT]);
   endsequence

   sequence s_retire_idle;
      ce && r_reg.mode == MODE_PEND && instr_done && !r_reg.pend_stop && !reset_any;
   endsequence

   property p_select_waits;
      @(posedge clk) disable iff (sys_rst)
      s_mode_write |=> power_mode == MODE_PEND && cpu_clk_en;
   endproperty
   a_select_waits: assert property (p_select_waits) else $error("mode write skipped pend");

   property p_idle_entry;
      @(posedge clk) disable iff (sys_rst)
      s_retire_idle |=> power_mode == MODE_IDLE && !cpu_clk_en && periph_clk_en && timer_en;
   endproperty
   a_idle_entry: assert property (p_idle_entry) else $error("idle entry wrong");

   property p_stop_outputs;
      @(posedge clk) disable iff (sys_rst)
      power_mode == MODE_STOP |-> !int_osc_en && !timer_en && !int_enable && !cpu_clk_en;
   endproperty
   a_stop_outputs: assert property (p_stop_outputs) else $error("stop left a clock on");

   property p_irq_wake;
      @(posedge clk) disable iff (sys_rst)
      ce && power_mode == MODE_IDLE && irq_pending && !r_reg.wake_lock && !reset_any
         |=> power_mode == MODE_RUN && irq_wake ##1 !irq_wake;
   endproperty
   a_irq_wake: assert property (p_irq_wake) else $error("interrupt did not wake idle");

   property p_idle_holds;
      @(posedge clk) disable iff (sys_rst)
      ce && power_mode == MODE_IDLE && !irq_pending && !reset_any |=> power_mode == MODE_IDLE;
   endproperty
   a_idle_holds: assert property (p_idle_holds) else $error("idle left without cause");

   property p_stop_no_irq;
      @(posedge clk) disable iff (sys_rst)
      ce && power_mode == MODE_STOP && !reset_any |=> power_mode == MODE_STOP;
   endproperty
   a_stop_no_irq: assert property (p_stop_no_irq) else $error("stop left without reset");

   property p_reset_restart;
      @(posedge clk) disable iff (sys_rst)
      ce && reset_any |=> reset_req && power_mode == MODE_RUN && restart_pc == 16'h0000;
   endproperty
   a_reset_restart: assert property (p_reset_restart) else $error("reset did not restart");

   property p_select_reads_zero;
      @(posedge clk) disable iff (sys_rst)
      ce && avs_read && !r_reg.ack && avs_address == OFS_POWER_CONTROL
         |=> avs_readdata[1:0] == 2'h0 && !avs_waitrequest;
   endproperty
   a_select_reads_zero: assert property (p_select_reads_zero) else $error("select bits read 1");

   property p_monitor_reset;
      @(posedge clk) disable iff (sys_rst)
      ce && mcm_expired && !pin_reset && !wd_expired
         |=> reset_req && r_reg.cause == CAUSE_MISSING_CLK;
   endproperty
   a_monitor_reset: assert property (p_monitor_reset) else $error("monitor reset missing");

   property p_watchdog_reset;
      @(posedge clk) disable iff (sys_rst)
      ce && wd_expired && !pin_reset |=> reset_req && r_reg.cause == CAUSE_WATCHDOG;
   endproperty
   a_watchdog_reset: assert property (p_watchdog_reset) else $error("watchdog reset missing");

   property p_wake_lock;
      @(posedge clk) disable iff (sys_rst)
      ce && r_reg.wake_lock && power_mode == MODE_IDLE && !reset_any |=> !irq_wake;
   endproperty
   a_wake_lock: assert property (p_wake_lock) else $error("wedged idle woke");

endmodule

/* verification/cpmc_core_model.sv */
// Model of the core, interrupt controller and reset pin facing the block
`timescale 1ns/1ps
module cpmc_core_model
   import cpmc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Block outputs seen by the core
   input wire logic [1:0] power_mode,
   input wire logic irq_wake,
   // Scenario controls
   input wire logic [3:0] done_gap,
   input wire logic single_byte,
   input wire logic irq_req,
   input wire logic pin_req,
   // Drives toward the block
   output logic instr_done,
   output logic next_single_byte,
   output logic irq_pending,
   output logic ext_reset_pin_n
);
   logic [3:0] gap_reg;
   logic retired_reg;
   logic served_reg;

   // Retire the power control write a chosen number of cycles late
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         gap_reg <= 4'h0;
         retired_reg <= 1'b0;
         instr_done <= 1'b0;
         served_reg <= 1'b0;
      end
      else
      begin
         instr_done <= 1'b0;
         if (power_mode != MODE_PEND)
         begin
            gap_reg <= 4'h0;
            retired_reg <= 1'b0;
         end
         else if (!retired_reg)
         begin
            gap_reg <= gap_reg + 4'h1;
            if (gap_reg == done_gap)
            begin
               instr_done <= 1'b1;
               retired_reg <= 1'b1;
            end
         end
         // Service routine clears its source, then returns to the next opcode
         if (irq_wake)
            served_reg <= 1'b1;
         else if (!irq_req)
            served_reg <= 1'b0;
      end
   end

   // Follower length chosen by the scenario; short ones provoke the hazard
   assign next_single_byte = single_byte;
   assign irq_pending = irq_req & ~served_reg;
   // Pin has a pull-up, so a released pin reads high
   assign ext_reset_pin_n = ~pin_req;
endmodule

/* verification/cpmc_power_ctrl_test.sv */
// Self-checking bench of the CPU power mode control block
`timescale 1ns/1ps
module cpu_power_mode_control_test
   import cpmc_pkg::*;
;
   localparam int MCM_N = 32;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata, rd;
   logic avs_waitrequest, instr_done, next_single_byte, cpu_clk_en, irq_pending;
   logic int_enable, irq_wake, ext_reset_pin_n, reset_req, periph_clk_en, timer_en, int_osc_en;
   logic [15:0] restart_pc;
   logic [1:0] power_mode;
   logic [3:0] done_gap = 4'h2;
   logic single_byte = 1'b0;
   logic irq_req = 1'b0;
   logic pin_req = 1'b0;
   int error_cnt = 0;
   int checks_done = 0;
   int cycles = 0;
   int n;

   cpmc_power_ctrl #(.MCM_TIMEOUT_CYCLES(MCM_N), .WATCHDOG_CYCLES(64)) dut (
      .clk, .sys_rst, .ce(1'b1), .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable(4'h1), .avs_readdata, .avs_waitrequest, .instr_done,
      .next_single_byte, .cpu_clk_en, .restart_pc, .power_mode, .irq_pending,
      .int_enable, .irq_wake, .ext_reset_pin_n, .reset_req, .periph_clk_en, .timer_en,
      .int_osc_en);

   cpmc_core_model core (
      .clk, .sys_rst, .power_mode, .irq_wake, .done_gap, .single_byte, .irq_req,
      .pin_req, .instr_done, .next_single_byte, .irq_pending, .ext_reset_pin_n);

   always #10 clk = ~clk;

   // Hang guard, well above the few hundred cycles the tests need
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         error_cnt++;
         give_verdict();
      end
   end

   task give_verdict();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task chk_reg(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task chk_sig(input string nm, input logic [3:0] exp, input logic [3:0] got);
      checks_done++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Hold the request until waitrequest is sampled low at a rising edge
   task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= d;
      do
      begin
         @(posedge clk);
         rd = avs_readdata;
      end
      while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   task rd_chk(input string nm, input logic [3:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk_reg(nm, exp, rd);
   endtask

   // Count cycles until a one-cycle pulse: irq_wake if sel, else reset_req
   task wait_evt(input logic sel, input int lim, output int cnt);
      cnt = 0;
      do
      begin
         @(posedge clk);
         cnt++;
      end
      while ((sel ? irq_wake : reset_req) !== 1'b1 && cnt < lim);
   endtask

   task wait_mode(input logic [1:0] m);
      n = 0;
      while (power_mode !== m && n < 20)
      begin
         @(posedge clk);
         n++;
      end
      chk_sig("power_mode", {2'h0, m}, {2'h0, power_mode});
   endtask

   task pin_reset();
      pin_req <= 1'b1;
      wait_evt(1'b0, 20, n);
      chk_reg("restart_pc", 32'h0000_0000, {16'h0, restart_pc});
      chk_sig("mode after reset", {2'h0, MODE_RUN}, {2'h0, power_mode});
      pin_req <= 1'b0;
      irq_req <= 1'b0;
   endtask

   initial
   begin
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      rd_chk("config", OFS_CONFIG, 32'h0000_0009);
      bus(1'b1, OFS_CONFIG, 32'h0000_0008);
      rd_chk("status", OFS_STATUS, 32'h0000_0000);
      rd_chk("unmapped", 4'h2, 32'h0000_0000);
      bus(1'b1, OFS_POWER_CONTROL, 32'h0000_00fc);
      rd_chk("power control", OFS_POWER_CONTROL, 32'h0000_00fc);
      // Idle entry waits for the write to retire, then holds until an interrupt
      bus(1'b1, OFS_POWER_CONTROL, 32'h0000_00fd);
      @(posedge clk);
      chk_sig("mode pending", {2'h0, MODE_PEND}, {2'h0, power_mode});
      chk_sig("cpu clock pending", 4'h1, {3'h0, cpu_clk_en});
      wait_mode(MODE_IDLE);
      chk_sig("idle enables", 4'h7, {cpu_clk_en, periph_clk_en, timer_en, int_osc_en});
      repeat (20) @(posedge clk);
      rd_chk("status idle", OFS_STATUS, 32'h0000_0003);
      rd_chk("flags idle", OFS_POWER_CONTROL, 32'h0000_00fc);
      irq_req <= 1'b1;
      wait_evt(1'b1, 20, n);
      chk_sig("irq wake", 4'h1, {3'h0, irq_wake});
      chk_sig("mode after wake", {2'h0, MODE_RUN}, {2'h0, power_mode});
      irq_req <= 1'b0;
      // Both bits written: stop wins; interrupts cannot end it
      bus(1'b1, OFS_POWER_CONTROL, 32'h0000_0003);
      wait_mode(MODE_STOP);
      chk_sig("stop enables", 4'h0, {cpu_clk_en, periph_clk_en, timer_en, int_osc_en});
      chk_sig("stop int enable", 4'h0, {3'h0, int_enable});
      irq_req <= 1'b1;
      repeat (10) @(posedge clk);
      chk_sig("stop holds", {2'h0, MODE_STOP}, {2'h0, power_mode});
      pin_reset();
      rd_chk("config after reset", OFS_CONFIG, 32'h0000_0009);
      bus(1'b1, OFS_CONFIG, 32'h0000_0004);
      rd_chk("cause pin", OFS_STATUS, 32'h0000_0008);
      // Monitor ends stop after its timeout
      bus(1'b1, OFS_POWER_CONTROL, 32'h0000_0002);
      wait_mode(MODE_STOP);
      wait_evt(1'b0, 100, n);
      chk_sig("monitor delay", 4'h1, {3'h0, n >= MCM_N && n <= MCM_N + 3});
      bus(1'b1, OFS_CONFIG, 32'h0000_0008);
      rd_chk("cause monitor", OFS_STATUS, 32'h0000_0018);
      // Short follower with an interrupt during the write locks out wakes
      single_byte <= 1'b1;
      done_gap <= 4'h4;
      bus(1'b1, OFS_POWER_CONTROL, 32'h0000_0001);
      irq_req <= 1'b1;
      wait_mode(MODE_IDLE);
      repeat (10) @(posedge clk);
      rd_chk("status locked", OFS_STATUS, 32'h0000_001f);
      pin_reset();
      single_byte <= 1'b0;
      // Locked watchdog stays enabled, refuses a disable and ends idle
      bus(1'b1, OFS_CONFIG, 32'h0000_0002);
      rd_chk("config locked", OFS_CONFIG, 32'h0000_0003);
      bus(1'b1, OFS_CONFIG, 32'h0000_0000);
      rd_chk("config still locked", OFS_CONFIG, 32'h0000_0003);
      bus(1'b1, OFS_WD_KICK, 32'h0000_0000);
      bus(1'b1, OFS_POWER_CONTROL, 32'h0000_0001);
      wait_mode(MODE_IDLE);
      wait_evt(1'b0, 200, n);
      chk_sig("watchdog end", {2'h0, MODE_RUN}, {2'h0, power_mode});
      bus(1'b1, OFS_CONFIG, 32'h0000_0008);
      rd_chk("cause watchdog", OFS_STATUS, 32'h0000_0010);
      give_verdict();
   end
endmodule
